/* File: rtl/irq_ctrl.sv */
// two-level interrupt controller with an AXI4-Lite register port
module irq_ctrl #(
	parameter int N = 8,
	parameter logic [31:0] PERIPH_MASK = 32'hFFFFFFF0
) (
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	// event sources and processor core
	input wire logic [N-1:0] SRC_EVENT,
	input wire logic IRQ_ACK,
	input wire logic RETURN_STROBE,
	output logic IRQ_REQ,
	output logic IRQ_LOW,
	output logic [irq_ctrl_pkg::VEC_W-1:0] IRQ_VECTOR,
	output logic IRQ,
	// AXI4-Lite write
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [irq_ctrl_pkg::DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [irq_ctrl_pkg::DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	if (N < 1 || N > 32) begin : g_bad_n
		$error("irq_ctrl: N must lie in 1..32");
	end

	logic ple_q, ple_d, glb_en_q, glb_en_d, per_en_q, per_en_d;
	logic hi_act_q, hi_act_d, lo_act_q, lo_act_d;
	logic [N-1:0] flag_q, flag_d, en_q, en_d, prio_q, prio_d;
	logic [irq_ctrl_pkg::EV_W-1:0] istat_q, istat_d, imask_q, imask_d;
	logic req_q, req_d, low_q, low_d, irq_q, irq_d;
	logic [irq_ctrl_pkg::VEC_W-1:0] vec_q, vec_d;
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] wmask, wbits;
	logic wr_do;
	logic [N-1:0] periph;

	assign periph = PERIPH_MASK[N-1:0];
	assign wr_do = aw_full_q & w_full_q & ~bvalid_q;

	for (genvar g = 0; g < 32; g++) begin : g_lane
		assign wmask[g] = wstrb_q[g / 8];
		assign wbits[g] = wdata_q[g] & wstrb_q[g / 8];
	end

	always_comb begin
		logic [N-1:0] live;
		logic [N-1:0] flag_clr;
		logic [irq_ctrl_pkg::EV_W-1:0] ev, ev_clr;
		logic hi_pend, lo_pend;
		live = '0;
		flag_clr = '0;
		ev = '0;
		ev_clr = '0;
		hi_pend = 1'b0;
		lo_pend = 1'b0;
		ple_d = ple_q;
		glb_en_d = glb_en_q;
		per_en_d = per_en_q;
		hi_act_d = hi_act_q;
		lo_act_d = lo_act_q;
		en_d = en_q;
		prio_d = prio_q;
		imask_d = imask_q;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		// write channel: address and data taken in either order
		if (AWVALID && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d = AWADDR;
		end
		if (WVALID && wready_q) begin
			w_full_d = 1'b1;
			wdata_d = WDATA;
			wstrb_d = WSTRB;
		end
		if (bvalid_q && BREADY) begin
			bvalid_d = 1'b0;
		end
		if (wr_do) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = irq_ctrl_pkg::RESP_OKAY;
			case (awaddr_q)
				irq_ctrl_pkg::OFF_CTRL: begin
					if (wmask[0]) begin
						ple_d = wdata_q[irq_ctrl_pkg::CTRL_PLE_BIT];
						glb_en_d = wdata_q[irq_ctrl_pkg::CTRL_GLB_EN_BIT];
						per_en_d = wdata_q[irq_ctrl_pkg::CTRL_PER_EN_BIT];
					end
				end
				irq_ctrl_pkg::OFF_FLAG: flag_clr = wbits[N-1:0];
				irq_ctrl_pkg::OFF_EN: en_d = (en_q & ~wmask[N-1:0]) | wbits[N-1:0];
				irq_ctrl_pkg::OFF_PRIO: prio_d = (prio_q & ~wmask[N-1:0]) | wbits[N-1:0];
				irq_ctrl_pkg::OFF_STATE: bresp_d = irq_ctrl_pkg::RESP_OKAY;
				irq_ctrl_pkg::OFF_ISTAT: ev_clr = wbits[irq_ctrl_pkg::EV_W-1:0];
				irq_ctrl_pkg::OFF_IMASK: begin
					imask_d = (imask_q & ~wmask[irq_ctrl_pkg::EV_W-1:0]) | wbits[irq_ctrl_pkg::EV_W-1:0];
				end
				default: bresp_d = irq_ctrl_pkg::RESP_SLVERR;
			endcase
		end
		awready_d = ~aw_full_d;
		wready_d = ~w_full_d;
		// an event in the clearing cycle survives: set wins over clear
		flag_d = (flag_q & ~flag_clr) | SRC_EVENT;
		// core acceptance and return; hardware overrides a same-cycle write
		if (IRQ_ACK && req_q) begin
			if (!ple_q) begin
				glb_en_d = 1'b0;
				ev[irq_ctrl_pkg::EV_HI_BIT] = 1'b1;
			end else if (low_q) begin
				per_en_d = 1'b0;
				lo_act_d = 1'b1;
				ev[irq_ctrl_pkg::EV_LO_BIT] = 1'b1;
			end else begin
				glb_en_d = 1'b0;
				hi_act_d = 1'b1;
				ev[irq_ctrl_pkg::EV_HI_BIT] = 1'b1;
			end
		end else if (RETURN_STROBE) begin
			ev[irq_ctrl_pkg::EV_RET_BIT] = 1'b1;
			if (!ple_q || hi_act_q) begin
				glb_en_d = 1'b1;
				hi_act_d = 1'b0;
			end else begin
				per_en_d = 1'b1;
				lo_act_d = 1'b0;
			end
		end
		// request is built from next-state values so an accepted one drops at once
		live = flag_d & en_d;
		if (ple_d) begin
			hi_pend = glb_en_d & |(live & prio_d);
			lo_pend = glb_en_d & per_en_d & |(live & ~prio_d);
			req_d = hi_pend | lo_pend;
			low_d = ~hi_pend & lo_pend;
		end else begin
			req_d = glb_en_d & |(live & (~periph | {N{per_en_d}}));
			low_d = 1'b0;
		end
		// one vector per level; the source is found by polling flags
		vec_d = low_d ? irq_ctrl_pkg::VEC_LOW : irq_ctrl_pkg::VEC_HIGH;
		istat_d = (istat_q & ~ev_clr) | ev;
		irq_d = |(istat_d & imask_d);
		// read channel
		if (rvalid_q && RREADY) begin
			rvalid_d = 1'b0;
		end
		if (ARVALID && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = irq_ctrl_pkg::RESP_OKAY;
			rdata_d = '0;
			case (ARADDR)
				irq_ctrl_pkg::OFF_CTRL: begin
					rdata_d[irq_ctrl_pkg::CTRL_PLE_BIT] = ple_q;
					rdata_d[irq_ctrl_pkg::CTRL_GLB_EN_BIT] = glb_en_q;
					rdata_d[irq_ctrl_pkg::CTRL_PER_EN_BIT] = per_en_q;
				end
				irq_ctrl_pkg::OFF_FLAG: rdata_d = 32'(flag_q);
				irq_ctrl_pkg::OFF_EN: rdata_d = 32'(en_q);
				irq_ctrl_pkg::OFF_PRIO: rdata_d = 32'(prio_q);
				irq_ctrl_pkg::OFF_STATE: begin
					rdata_d[irq_ctrl_pkg::ST_HIACT_BIT] = hi_act_q;
					rdata_d[irq_ctrl_pkg::ST_LOACT_BIT] = lo_act_q;
					rdata_d[irq_ctrl_pkg::ST_REQ_BIT] = req_q;
					rdata_d[irq_ctrl_pkg::ST_LOW_BIT] = low_q;
					rdata_d[irq_ctrl_pkg::ST_VEC_LSB +: irq_ctrl_pkg::VEC_W] = vec_q;
				end
				irq_ctrl_pkg::OFF_ISTAT: rdata_d = 32'(istat_q);
				irq_ctrl_pkg::OFF_IMASK: rdata_d = 32'(imask_q);
				default: rresp_d = irq_ctrl_pkg::RESP_SLVERR;
			endcase
		end
		// ready from the first edge after reset, and again once the answer is taken
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ple_q <= irq_ctrl_pkg::CTRL_RESET;
			glb_en_q <= irq_ctrl_pkg::CTRL_RESET;
			per_en_q <= irq_ctrl_pkg::CTRL_RESET;
			hi_act_q <= 1'b0;
			lo_act_q <= 1'b0;
			flag_q <= '0;
			en_q <= '0;
			prio_q <= '0;
			istat_q <= irq_ctrl_pkg::EV_RESET;
			imask_q <= irq_ctrl_pkg::EV_RESET;
			req_q <= 1'b0;
			low_q <= 1'b0;
			vec_q <= irq_ctrl_pkg::VEC_HIGH;
			irq_q <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= irq_ctrl_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= irq_ctrl_pkg::RESP_OKAY;
		end else if (CE) begin
			ple_q <= ple_d;
			glb_en_q <= glb_en_d;
			per_en_q <= per_en_d;
			hi_act_q <= hi_act_d;
			lo_act_q <= lo_act_d;
			flag_q <= flag_d;
			en_q <= en_d;
			prio_q <= prio_d;
			istat_q <= istat_d;
			imask_q <= imask_d;
			req_q <= req_d;
			low_q <= low_d;
			vec_q <= vec_d;
			irq_q <= irq_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign IRQ_REQ = req_q;
	assign IRQ_LOW = low_q;
	assign IRQ_VECTOR = vec_q;
	assign IRQ = irq_q;
	assign AWREADY = awready_q;
	assign WREADY = wready_q;
	assign BRESP = bresp_q;
	assign BVALID = bvalid_q;
	assign ARREADY = arready_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign RVALID = rvalid_q;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	vec_level_a: assert property (IRQ_REQ && ple_q |-> IRQ_VECTOR == (IRQ_LOW ? 16'h0018 : 16'h0008))
		else $error("vector does not match level");
	compat_vec_a: assert property (IRQ_REQ && !ple_q |-> IRQ_VECTOR == 16'h0008 && !IRQ_LOW)
		else $error("compat vector not 0008h");
	compat_nolow_a: assert property (!ple_q && (|(flag_q & en_q & prio_q)) |-> !IRQ_LOW)
		else $error("priority select used in compat mode");
	compat_periph_a: assert property (IRQ_REQ && !ple_q |->
		glb_en_q && |(flag_q & en_q & (~periph | {N{per_en_q}})))
		else $error("compat request without enabling source");
	compat_glb_a: assert property (!ple_q && glb_en_q && |(flag_q & en_q & ~periph) |-> IRQ_REQ)
		else $error("non-peripheral source not requested");
	high_gate_a: assert property (IRQ_REQ && ple_q |-> glb_en_q)
		else $error("request with high enable clear");
	low_gate_a: assert property (IRQ_REQ && IRQ_LOW |-> per_en_q && glb_en_q && |(flag_q & en_q & ~prio_q))
		else $error("low request not enabled");
	preempt_a: assert property (ple_q && lo_act_q && glb_en_q && |(flag_q & en_q & prio_q) |->
		IRQ_REQ && !IRQ_LOW)
		else $error("high source did not preempt low service");
	accept_clr_a: assert property (CE && IRQ_ACK && IRQ_REQ && !IRQ_LOW |=> !glb_en_q && !IRQ_REQ)
		else $error("accept did not clear global enable");
	return_set_a: assert property (CE && RETURN_STROBE && !(IRQ_ACK && IRQ_REQ) && !ple_q |=> glb_en_q)
		else $error("return did not set global enable");
	flag_set_a: assert property (CE |=> (flag_q & $past(SRC_EVENT)) == $past(SRC_EVENT))
		else $error("event lost");
	flag_hold_a: assert property (CE && !(wr_do && awaddr_q == irq_ctrl_pkg::OFF_FLAG) |=>
		(flag_q & $past(flag_q)) == $past(flag_q))
		else $error("flag dropped without a clear");

	cov_compat_c: cover property (!ple_q && IRQ_REQ && IRQ_ACK);
	cov_low_c: cover property (ple_q && IRQ_REQ && IRQ_LOW && IRQ_ACK);
	cov_preempt_c: cover property (lo_act_q && IRQ_REQ && !IRQ_LOW && IRQ_ACK);
	cov_return_c: cover property (hi_act_q && RETURN_STROBE);
endmodule

/* File: rtl/irq_ctrl_pkg.sv */
// constants shared by the two-level interrupt controller
package irq_ctrl_pkg;
	// bus geometry and responses
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_EN = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PRIO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h18;
	// control register fields
	localparam int CTRL_PLE_BIT = 0;
	localparam int CTRL_GLB_EN_BIT = 1;
	localparam int CTRL_PER_EN_BIT = 2;
	localparam logic CTRL_RESET = 1'b0;
	// state register fields
	localparam int ST_HIACT_BIT = 0;
	localparam int ST_LOACT_BIT = 1;
	localparam int ST_REQ_BIT = 2;
	localparam int ST_LOW_BIT = 3;
	localparam int ST_VEC_LSB = 16;
	// event status and mask layout
	localparam int EV_W = 3;
	localparam int EV_HI_BIT = 0;
	localparam int EV_LO_BIT = 1;
	localparam int EV_RET_BIT = 2;
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;
	// branch targets
	localparam int VEC_W = 16;
	localparam logic [VEC_W-1:0] VEC_HIGH = 16'h0008;
	localparam logic [VEC_W-1:0] VEC_LOW = 16'h0018;
endpackage

/* File: sim/core_model.sv */
// processor core model: takes an offered interrupt after a chosen delay
module core_model (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// controller side
	input wire logic IRQ_REQ,
	input wire logic IRQ_LOW,
	input wire logic [irq_ctrl_pkg::VEC_W-1:0] IRQ_VECTOR,
	output logic IRQ_ACK,
	// bench side
	input wire logic ack_en,
	input wire logic [3:0] delay,
	output logic [irq_ctrl_pkg::VEC_W-1:0] vec_seen,
	output logic low_seen,
	output logic [7:0] acks
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	// no ack right after an ack: the request only drops one cycle later
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ_ACK <= 1'b0;
			cnt_q <= 4'h0;
			vec_seen <= 16'h0000;
			low_seen <= 1'b0;
			acks <= 8'h00;
		end else begin
			IRQ_ACK <= 1'b0;
			cnt_q <= 4'h0;
			if (IRQ_REQ && ack_en && !IRQ_ACK) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q >= delay) begin
					IRQ_ACK <= 1'b1;
					cnt_q <= 4'h0;
					vec_seen <= IRQ_VECTOR;
					low_seen <= IRQ_LOW;
					acks <= acks + 8'h01;
				end
			end
		end
	end
endmodule

/* File: sim/irq_ctrl_tb.sv */
// self-checking bench for the two-level interrupt controller
module irq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PERI = 8'hF0;
	logic REF_CLK, RST, CE, IRQ_ACK, RETURN_STROBE, IRQ_REQ, IRQ_LOW, IRQ, ack_en, low_seen;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic [7:0] SRC_EVENT, AWADDR, ARADDR, acks, e, p, s;
	logic [15:0] IRQ_VECTOR, vec_seen;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0] WSTRB, delay;
	logic [1:0] BRESP, RRESP, resp;
	logic [2:0] c;
	logic [17:0] x;
	int failures, checked, cycles, seed;
	irq_ctrl #(.N(8), .PERIPH_MASK({24'hFFFFFF, PERI})) i_irq_ctrl (.REF_CLK, .RST, .CE, .SRC_EVENT, .IRQ_ACK,
		.RETURN_STROBE, .IRQ_REQ, .IRQ_LOW, .IRQ_VECTOR, .IRQ, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	core_model i_core_model (.REF_CLK, .RST, .IRQ_REQ, .IRQ_LOW, .IRQ_VECTOR, .IRQ_ACK, .ack_en, .delay,
		.vec_seen, .low_seen, .acks);
	task automatic print_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge REF_CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		resp = BRESP;
		BREADY <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a);
		@(posedge REF_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge REF_CLK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		rd = RDATA;
		resp = RRESP;
		RREADY <= 1'b0;
	endtask
	task automatic pulse(input logic [7:0] m, input logic r);
		@(posedge REF_CLK);
		SRC_EVENT <= m;
		RETURN_STROBE <= r;
		@(posedge REF_CLK);
		SRC_EVENT <= 8'h00;
		RETURN_STROBE <= 1'b0;
	endtask
	task automatic wait_ack(input logic [7:0] n);
		for (int i = 0; i < 40 && acks !== n; i++) @(posedge REF_CLK);
		repeat (2) @(posedge REF_CLK);
		chk({24'h0, acks}, {24'h0, n});
	endtask
	// expected {low, request, vector} with no service in progress
	function automatic logic [17:0] exp_irq(logic [2:0] k, logic [7:0] f, logic [7:0] en, logic [7:0] pr);
		logic [7:0] hi;
		logic [7:0] lo;
		logic low;
		hi = f & en & {8{k[irq_ctrl_pkg::CTRL_GLB_EN_BIT]}};
		lo = 8'h00;
		if (!k[irq_ctrl_pkg::CTRL_PLE_BIT])
			hi = hi & (~PERI | {8{k[irq_ctrl_pkg::CTRL_PER_EN_BIT]}});
		else begin
			lo = hi & ~pr & {8{k[irq_ctrl_pkg::CTRL_PER_EN_BIT]}};
			hi = hi & pr;
		end
		low = (hi == 8'h00) && (lo != 8'h00);
		return {low, |(hi | lo), low ? irq_ctrl_pkg::VEC_LOW : irq_ctrl_pkg::VEC_HIGH};
	endfunction
	always #10 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		{REF_CLK, RST, CE, RETURN_STROBE, ack_en} = 5'b01100;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{SRC_EVENT, AWADDR, ARADDR, WDATA} = 56'h0;
		WSTRB = 4'hF;
		delay = 4'h0;
		seed = 32'hE132FB79;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h00000000);
		rdw(irq_ctrl_pkg::OFF_STATE);
		chk(rd, 32'h00080000);
		rdw(8'h40);
		chk({30'h0, resp}, {30'h0, irq_ctrl_pkg::RESP_SLVERR});
		wr(8'h40, 32'hFFFFFFFF);
		chk({30'h0, resp}, {30'h0, irq_ctrl_pkg::RESP_SLVERR});
		// first eight passes walk every control setting, the rest are random
		for (int i = 0; i < 40; i++) begin
			c = (i < 8) ? 3'(i) : 3'($random(seed));
			e = 8'($random(seed));
			p = 8'($random(seed));
			s = 8'($random(seed));
			wr(irq_ctrl_pkg::OFF_FLAG, 32'hFF);
			wr(irq_ctrl_pkg::OFF_EN, {24'h0, e});
			wr(irq_ctrl_pkg::OFF_PRIO, {24'h0, p});
			wr(irq_ctrl_pkg::OFF_CTRL, {29'h0, c});
			pulse(s, 1'b0);
			repeat (2) @(posedge REF_CLK);
			x = exp_irq(c, s, e, p);
			chk({30'h0, IRQ_LOW, IRQ_REQ}, {30'h0, x[17:16]});
			chk({31'h0, IRQ_REQ}, {31'h0, x[16]});
			chk({16'h0, IRQ_VECTOR}, {16'h0, x[15:0]});
			rdw(irq_ctrl_pkg::OFF_FLAG);
			chk(rd, {24'h0, s});
		end
		wr(irq_ctrl_pkg::OFF_FLAG, 32'hFF);
		wr(irq_ctrl_pkg::OFF_EN, 32'hFF);
		wr(irq_ctrl_pkg::OFF_PRIO, 32'h01);
		wr(irq_ctrl_pkg::OFF_CTRL, 32'h07);
		ack_en <= 1'b1;
		delay <= 4'h5;
		pulse(8'h02, 1'b0);
		wait_ack(8'h01);
		chk({15'h0, low_seen, vec_seen}, {15'h0, 1'b1, irq_ctrl_pkg::VEC_LOW});
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h3);
		delay <= 4'h0;
		pulse(8'h01, 1'b0);
		wait_ack(8'h02);
		chk({15'h0, low_seen, vec_seen}, {15'h0, 1'b0, irq_ctrl_pkg::VEC_HIGH});
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h1);
		rdw(irq_ctrl_pkg::OFF_STATE);
		chk(rd, 32'h00080003);
		wr(irq_ctrl_pkg::OFF_FLAG, 32'hFF);
		pulse(8'h00, 1'b1);
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h3);
		pulse(8'h00, 1'b1);
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h7);
		chk({31'h0, IRQ_REQ}, 32'h0);
		rdw(irq_ctrl_pkg::OFF_ISTAT);
		chk(rd, 32'h7);
		chk({31'h0, IRQ}, 32'h0);
		wr(irq_ctrl_pkg::OFF_IMASK, 32'h4);
		repeat (2) @(posedge REF_CLK);
		chk({31'h0, IRQ}, 32'h1);
		wr(irq_ctrl_pkg::OFF_ISTAT, 32'h4);
		repeat (2) @(posedge REF_CLK);
		chk({31'h0, IRQ}, 32'h0);
		rdw(irq_ctrl_pkg::OFF_ISTAT);
		chk(rd, 32'h3);
		// compat accept and return; an event while the clock enable is low is lost
		wr(irq_ctrl_pkg::OFF_CTRL, 32'h06);
		CE <= 1'b0;
		pulse(8'h10, 1'b0);
		CE <= 1'b1;
		rdw(irq_ctrl_pkg::OFF_FLAG);
		chk(rd, 32'h0);
		pulse(8'h10, 1'b0);
		wait_ack(8'h03);
		chk({15'h0, low_seen, vec_seen}, {15'h0, 1'b0, irq_ctrl_pkg::VEC_HIGH});
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h4);
		wr(irq_ctrl_pkg::OFF_FLAG, 32'hFF);
		pulse(8'h00, 1'b1);
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h6);
		// second reset in mid-run must bring back the reset state
		RST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		rdw(irq_ctrl_pkg::OFF_CTRL);
		chk(rd, 32'h0);
		rdw(irq_ctrl_pkg::OFF_STATE);
		chk(rd, 32'h00080000);
		chk({31'h0, IRQ}, 32'h0);
		print_verdict();
	end
endmodule
